/* hw/cpm_params.svh */
// Offsets, reset values, field positions and timing for the clock prescale block.
// Assumes a 100 MHz bus clock and AXI4-Lite byte addressing.
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH
`define CPM_OFF_FAST      8'h00
`define CPM_OFF_SLOW      8'h04
`define CPM_OFF_AUX       8'h08
`define CPM_OFF_CLKCTL    8'h0c
`define CPM_OFF_PMCTL     8'h10
`define CPM_OFF_STATUS    8'h14
`define CPM_RST_FAST      8'h4f
`define CPM_RST_SLOW      8'hb6
`define CPM_RST_AUX       8'hff
`define CPM_RST_CLKCTL    8'h06
`define CPM_MODE_3X       3'h3
`define CPM_MODE_4X       3'h4
`define CPM_MODE_5X       3'h5
`define CPM_CC_SLOWSEL    0
`define CPM_CC_FASTSEL    1
`define CPM_CC_PLL_POWER_DOWN_BIT     2
`define CPM_CC_AUX1EN     3
`define CPM_CC_AUX2EN     4
`define CPM_PM_SAVE       0
`define CPM_PM_IDLE       1
`define CPM_PM_HALT       2
`define CPM_PM_DISMAIN    4
`define CPM_PM_DISPLL     5
`define CPM_PM_HCMAIN     6
`define CPM_PM_HCPLL      7
`define CPM_PLL_LOCK_NS   100000
`define CPM_CLK_NS        10
`define CPM_PLL_LOCK_CYC  ((`CPM_PLL_LOCK_NS + `CPM_CLK_NS - 1) / `CPM_CLK_NS)
`endif

/* hw/cpm_pkg.sv */
// Types for the clock prescale and power mode block.
// Assumes cpm_params.svh for numeric constants.
package cpm_pkg;
    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_SAVE,
        PM_IDLE,
        PM_HALT
    } cpm_mode_t;
endpackage

/* hw/cpm_top.sv */
// Clock prescalers, power mode clock gating and AXI4-Lite register slave.
// Assumes one 100 MHz clock; generated clocks are enables of one aclk cycle.
// Functional notes
// - System divider divides by fast divisor plus one
// - Multiplier codes 3,4,5 give 3x,4x,5x
// - Multiplier resets to 4x code
// - Slow clock divides main by 2(n+1)
// - Aux one divides main by n+1
// - Aux two divides main by n+1
// - Modes select system, timer clocks, oscillator
// - Halt stops slow clock; low oscillator runs
// - Main off in save/idle only with low-osc slow
// - Wake-up processed in save, idle and halt
// - Halt stops converter clock, converter left enabled
// - Wait stalls processor until interrupt
// - Aux clocks need running main clock
// - Idle gates system clock, slow clock runs
// - Halt stops clocks, oscillator and PLL
// - Link sleep lets hardware gate oscillator/PLL
// - Hardware bits gate main/PLL during link sleep
// - Disable bits override hardware control
// - Active/halt ignore disable and hardware bits
// - PLL power-down affects PLL only, every mode
// - Switch to PLL ignored if down/unstable
// - Aux clock runs only enabled and main stable
//
// The AXI4-Lite register port and the register addresses were decided locally.
`include "cpm_params.svh"
module cpm_top #(
    parameter int unsigned PLL_LOCK_CYC = `CPM_PLL_LOCK_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        wait_exec,
    input  wire logic        irq_pending,
    input  wire logic        wake_event,
    input  wire logic        link_sleep,
    input  wire logic        low_osc_tick,
    input  wire logic        main_osc_stable,
    output logic             main_osc_enable,
    output logic             pll_enable,
    output logic [2:0]       pll_multiplier,
    output logic             sys_clk_en,
    output logic             slow_clk_en,
    output logic             timer_clk_en,
    output logic             aux1_clk_en,
    output logic             aux2_clk_en,
    output logic             cpu_stall
);
    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0]  fast_q, slow_q, aux_q, clkctl_q, pmctl_q;
    logic [7:0]  pmctl_d, clkctl_d;
    cpm_pkg::cpm_mode_t mode_q, mode_d;
    logic        stall_q, wake_hold_q;
    logic [31:0] lock_cnt_q;
    logic        pll_stable_q;
    logic        aw_hold_q, w_hold_q;
    logic [7:0]  awaddr_q;
    logic [7:0]  wdata_q;
    logic        bvalid_q, rvalid_q;
    logic [31:0] rdata_q;

    // ==========================================================
    // Write channel: address and data taken in either order
    // ==========================================================
    wire aw_take  = s_axi_awvalid && !aw_hold_q && !bvalid_q;
    wire w_take   = s_axi_wvalid && !w_hold_q && !bvalid_q;
    wire aw_have  = aw_hold_q || aw_take;
    wire w_have   = w_hold_q || w_take;
    wire wr_fire  = aw_have && w_have && !bvalid_q;
    wire [7:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [7:0] wr_byte = w_hold_q ? wdata_q : s_axi_wdata[7:0];
    wire wr_lane  = w_hold_q ? 1'b1 : s_axi_wstrb[0];
    wire wr_ok    = wr_addr == `CPM_OFF_FAST || wr_addr == `CPM_OFF_SLOW || wr_addr == `CPM_OFF_AUX
                 || wr_addr == `CPM_OFF_CLKCTL || wr_addr == `CPM_OFF_PMCTL || wr_addr == `CPM_OFF_STATUS;
    wire wr_en    = wr_fire && wr_lane;
    wire wr_fast  = wr_en && wr_addr == `CPM_OFF_FAST;
    wire wr_slow  = wr_en && wr_addr == `CPM_OFF_SLOW;
    wire wr_aux   = wr_en && wr_addr == `CPM_OFF_AUX;
    wire wr_cc    = wr_en && wr_addr == `CPM_OFF_CLKCTL;
    wire wr_pm    = wr_en && wr_addr == `CPM_OFF_PMCTL;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;

    logic [1:0] bresp_q, rresp_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 8'h00;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
        end else begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? 2'h0 : 2'h2;
            end else begin
                if (aw_take) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q  <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_hold_q <= s_axi_wstrb[0] || 1'b1;
                    wdata_q  <= s_axi_wdata[7:0];
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    wire [7:0] status_byte = {4'h0, pll_stable_q, main_osc_stable, mode_q};
    logic [7:0] rd_byte;
    logic       rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `CPM_OFF_FAST:   rd_byte = fast_q;
            `CPM_OFF_SLOW:   rd_byte = slow_q;
            `CPM_OFF_AUX:    rd_byte = aux_q;
            `CPM_OFF_CLKCTL: rd_byte = clkctl_q;
            `CPM_OFF_PMCTL:  rd_byte = pmctl_q;
            `CPM_OFF_STATUS: rd_byte = status_byte;
            default: begin
                rd_byte = 8'h00;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Prescaler registers
    // ==========================================================
    wire [2:0] mode_wr = wr_byte[6:4];
    wire mode_legal = mode_wr == `CPM_MODE_3X || mode_wr == `CPM_MODE_4X || mode_wr == `CPM_MODE_5X;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_q <= `CPM_RST_FAST;
            slow_q <= `CPM_RST_SLOW;
            aux_q  <= `CPM_RST_AUX;
        end else begin
            // Reserved multiplier codes keep the previous code
            if (wr_fast) begin
                fast_q <= {1'b0, mode_legal ? mode_wr : fast_q[6:4], wr_byte[3:0]};
            end
            if (wr_slow) begin
                slow_q <= wr_byte;
            end
            if (wr_aux) begin
                aux_q <= wr_byte;
            end
        end
    end
    assign pll_multiplier = fast_q[6:4];

    // ==========================================================
    // Clock select and power mode control
    // ==========================================================
    wire cc_pll_sel  = !clkctl_q[`CPM_CC_FASTSEL];
    wire cc_pll_power_down_bit   = clkctl_q[`CPM_CC_PLL_POWER_DOWN_BIT];
    wire cc_low_slow = clkctl_q[`CPM_CC_SLOWSEL];

    always_comb begin
        clkctl_d = clkctl_q;
        if (wr_cc) begin
            clkctl_d = {3'h0, wr_byte[4:0]};
            // Clearing the select bit picks the PLL: refuse unless PLL up and locked
            if (!wr_byte[`CPM_CC_FASTSEL] && (wr_byte[`CPM_CC_PLL_POWER_DOWN_BIT] || cc_pll_power_down_bit || !pll_stable_q)) begin
                clkctl_d[`CPM_CC_FASTSEL] = 1'b1;
            end
            if (wr_byte[`CPM_CC_PLL_POWER_DOWN_BIT] && cc_pll_sel) begin
                clkctl_d[`CPM_CC_PLL_POWER_DOWN_BIT] = 1'b0;
            end
        end
    end

    wire save_req = pmctl_q[`CPM_PM_SAVE];
    wire idle_req = pmctl_q[`CPM_PM_IDLE];
    wire halt_req = pmctl_q[`CPM_PM_HALT];
    wire low_pm   = mode_q == cpm_pkg::PM_SAVE || mode_q == cpm_pkg::PM_IDLE;

    always_comb begin
        pmctl_d = pmctl_q;
        mode_d  = mode_q;
        if (wr_pm) begin
            pmctl_d = wr_byte;
        end
        // Wake has priority over a same-cycle software write
        if (wake_event) begin
            pmctl_d[`CPM_PM_SAVE] = 1'b0;
            pmctl_d[`CPM_PM_IDLE] = 1'b0;
            pmctl_d[`CPM_PM_DISMAIN] = 1'b0;
            pmctl_d[`CPM_PM_DISPLL] = 1'b0;
            if (mode_q != cpm_pkg::PM_HALT || main_osc_stable) begin
                pmctl_d[`CPM_PM_HALT] = 1'b0;
            end
        end
        case (mode_q)
            cpm_pkg::PM_ACTIVE: begin
                if (wait_exec && halt_req) begin
                    mode_d = cpm_pkg::PM_HALT;
                end else if (wait_exec && idle_req) begin
                    mode_d = cpm_pkg::PM_IDLE;
                end else if (save_req) begin
                    mode_d = cpm_pkg::PM_SAVE;
                end
            end
            cpm_pkg::PM_SAVE, cpm_pkg::PM_IDLE: begin
                if (!pmctl_d[`CPM_PM_SAVE] && !pmctl_d[`CPM_PM_IDLE] && main_osc_stable) begin
                    mode_d = cpm_pkg::PM_ACTIVE;
                end
            end
            cpm_pkg::PM_HALT: begin
                // Wake restarts the oscillator; leave only once it is stable
                if ((wake_event || wake_hold_q) && main_osc_stable) begin
                    mode_d = cpm_pkg::PM_ACTIVE;
                end
            end
            default: mode_d = cpm_pkg::PM_ACTIVE;
        endcase
        if (mode_d == cpm_pkg::PM_ACTIVE && mode_q != cpm_pkg::PM_ACTIVE) begin
            pmctl_d[`CPM_PM_HCMAIN] = 1'b0;
            pmctl_d[`CPM_PM_HCPLL]  = 1'b0;
            pmctl_d[`CPM_PM_HALT]   = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clkctl_q <= `CPM_RST_CLKCTL;
            pmctl_q  <= 8'h00;
            mode_q   <= cpm_pkg::PM_ACTIVE;
            stall_q  <= 1'b0;
            wake_hold_q <= 1'b0;
        end else begin
            clkctl_q <= clkctl_d;
            pmctl_q  <= pmctl_d;
            mode_q   <= mode_d;
            // Wake pulse may end before the oscillator settles
            wake_hold_q <= mode_d == cpm_pkg::PM_HALT && (wake_hold_q || wake_event);
            if (wait_exec) begin
                stall_q <= 1'b1;
            end else if (irq_pending || wake_event) begin
                stall_q <= 1'b0;
            end
        end
    end
    assign cpu_stall = stall_q || wait_exec;

    // ==========================================================
    // Oscillator and PLL enables
    // ==========================================================
    wire hc_main = pmctl_q[`CPM_PM_HCMAIN] && link_sleep;
    wire hc_pll  = pmctl_q[`CPM_PM_HCPLL] && link_sleep;
    // Main may only stop in low modes when slow clock runs from the low oscillator
    wire main_off_low = cc_low_slow && (pmctl_q[`CPM_PM_DISMAIN] || hc_main);
    wire pll_off_low  = pmctl_q[`CPM_PM_DISPLL] || hc_pll;
    // Active and halt ignore disable and hardware bits
    assign main_osc_enable = mode_q == cpm_pkg::PM_ACTIVE
                          || (low_pm && !main_off_low) || wake_hold_q;
    assign pll_enable = !cc_pll_power_down_bit && (mode_q == cpm_pkg::PM_ACTIVE || (low_pm && !pll_off_low));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_cnt_q   <= 32'h0000_0000;
            pll_stable_q <= 1'b0;
        end else if (!pll_enable || !main_osc_stable) begin
            lock_cnt_q   <= 32'h0000_0000;
            pll_stable_q <= 1'b0;
        end else if (lock_cnt_q >= PLL_LOCK_CYC) begin
            pll_stable_q <= 1'b1;
        end else begin
            lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Dividers: count enables, reload divisor only at terminal
    // ==========================================================
    wire main_run = main_osc_enable && main_osc_stable && mode_q != cpm_pkg::PM_HALT;
    wire fast_src = cc_pll_sel ? pll_stable_q : main_run;
    logic [3:0] fdiv_q, fcnt_q, a1div_q, a1cnt_q, a2div_q, a2cnt_q;
    logic [8:0] sdiv_q, scnt_q;
    wire f_tc  = fcnt_q == fdiv_q;
    wire a1_tc = a1cnt_q == a1div_q;
    wire a2_tc = a2cnt_q == a2div_q;
    wire s_tc  = scnt_q == sdiv_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fdiv_q  <= 4'hf;
            fcnt_q  <= 4'h0;
            a1div_q <= 4'hf;
            a1cnt_q <= 4'h0;
            a2div_q <= 4'hf;
            a2cnt_q <= 4'h0;
            sdiv_q  <= 9'h16d;
            scnt_q  <= 9'h000;
        end else begin
            if (fast_src) begin
                fcnt_q <= f_tc ? 4'h0 : fcnt_q + 4'h1;
                if (f_tc) fdiv_q <= fast_q[3:0];
            end
            if (main_run) begin
                a1cnt_q <= a1_tc ? 4'h0 : a1cnt_q + 4'h1;
                if (a1_tc) a1div_q <= aux_q[3:0];
                a2cnt_q <= a2_tc ? 4'h0 : a2cnt_q + 4'h1;
                if (a2_tc) a2div_q <= aux_q[7:4];
                scnt_q <= s_tc ? 9'h000 : scnt_q + 9'h001;
                // Twice (n+1) minus one keeps a 2(n+1) period
                if (s_tc) sdiv_q <= {slow_q, 1'b1};
            end
        end
    end

    // ==========================================================
    // Clock gating by mode
    // ==========================================================
    wire slow_tick = cc_low_slow ? low_osc_tick : (main_run && s_tc);
    assign slow_clk_en  = mode_q != cpm_pkg::PM_HALT && slow_tick;
    assign timer_clk_en = slow_clk_en;
    always_comb begin
        case (mode_q)
            cpm_pkg::PM_ACTIVE: sys_clk_en = fast_src && f_tc;
            cpm_pkg::PM_SAVE:   sys_clk_en = slow_clk_en;
            cpm_pkg::PM_IDLE:   sys_clk_en = 1'b0;
            cpm_pkg::PM_HALT:   sys_clk_en = 1'b0;
            default:            sys_clk_en = 1'b0;
        endcase
    end
    // Aux clocks also feed the converter; halt stops them but leaves converter enabled
    assign aux1_clk_en = clkctl_q[`CPM_CC_AUX1EN] && main_run && a1_tc;
    assign aux2_clk_en = clkctl_q[`CPM_CC_AUX2EN] && main_run && a2_tc;
endmodule

/* verification/cpm_props.sv */
// Checker on the ports of cpm_top: stall, multiplier and derived clock gating.
// Assumes it is bound to cpm_top; everything samples on aclk.
module cpm_props (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       wait_exec,
    input wire logic       irq_pending,
    input wire logic       wake_event,
    input wire logic       main_osc_stable,
    input wire logic       main_osc_enable,
    input wire logic [2:0] pll_multiplier,
    input wire logic       slow_clk_en,
    input wire logic       timer_clk_en,
    input wire logic       aux1_clk_en,
    input wire logic       aux2_clk_en,
    input wire logic       cpu_stall
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================
    // Properties
    property p_mult_rst;
        !$past(aresetn) |-> pll_multiplier == 3'h4;
    endproperty
    property p_mult_legal;
        pll_multiplier inside {3'h3, 3'h4, 3'h5};
    endproperty
    // One cycle of slack: stability may be seen through a register
    property p_aux1_stable;
        aux1_clk_en |-> main_osc_stable || $past(main_osc_stable);
    endproperty
    property p_aux2_stable;
        aux2_clk_en |-> main_osc_stable || $past(main_osc_stable);
    endproperty
    property p_aux_main;
        aux1_clk_en || aux2_clk_en |-> main_osc_enable || $past(main_osc_enable);
    endproperty
    property p_stall_rise;
        $rose(cpu_stall) |-> wait_exec || $past(wait_exec);
    endproperty
    property p_stall_hold;
        cpu_stall && !irq_pending && !wait_exec && !wake_event ##1 !irq_pending |-> cpu_stall;
    endproperty
    property p_stall_clear;
        cpu_stall && irq_pending && !wait_exec |-> ##[0:2] !cpu_stall;
    endproperty
    property p_timer_slow;
        timer_clk_en |-> slow_clk_en;
    endproperty
    a_mult_rst: assert property (p_mult_rst) else $error("multiplier not 4x after reset");
    a_mult_legal: assert property (p_mult_legal) else $error("reserved multiplier code");
    a_aux1_stable: assert property (p_aux1_stable) else $error("aux one runs unstable");
    a_aux2_stable: assert property (p_aux2_stable) else $error("aux two runs unstable");
    a_aux_main: assert property (p_aux_main) else $error("aux clock without main");
    a_stall_rise: assert property (p_stall_rise) else $error("stall without wait");
    a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");
    a_stall_clear: assert property (p_stall_clear) else $error("stall kept after irq");
    a_timer_slow: assert property (p_timer_slow) else $error("timer tick off slow clock");
    c_aux1: cover property (aux1_clk_en);
    c_stall: cover property ($rose(cpu_stall));
    c_main_off: cover property (!main_osc_enable);
endmodule
bind cpm_top cpm_props i_props (.aclk(aclk), .aresetn(aresetn), .wait_exec(wait_exec), .wake_event(wake_event),
    .irq_pending(irq_pending), .main_osc_stable(main_osc_stable), .main_osc_enable(main_osc_enable),
    .pll_multiplier(pll_multiplier), .slow_clk_en(slow_clk_en), .timer_clk_en(timer_clk_en),
    .aux1_clk_en(aux1_clk_en), .aux2_clk_en(aux2_clk_en), .cpu_stall(cpu_stall));

/* verification/cpm_osc_model.sv */
// Oscillator side of cpm_top: main oscillator start-up and the low-rate tick.
// Assumes one aclk; oscillator times are scaled down to aclk cycles.
module cpm_osc_model #(
    parameter int START_CYC = 6,
    parameter int LOW_DIV   = 16
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic main_osc_enable,
    output logic      main_osc_stable,
    output logic      low_osc_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int start_q = 0;
    int tick_q = 0;
    // Low oscillator never stops, not even in reset
    always_ff @(posedge aclk) begin
        tick_q <= (tick_q >= LOW_DIV - 1) ? 0 : tick_q + 1;
    end
    assign low_osc_tick = (tick_q == LOW_DIV - 1);
    // Stability lost at the first edge after disable, regained only after start-up
    always_ff @(posedge aclk) begin
        if (!aresetn || !main_osc_enable) start_q <= 0;
        else if (start_q < START_CYC) start_q <= start_q + 1;
    end
    assign main_osc_stable = (start_q == START_CYC);
endmodule

/* verification/tb_top.sv */
// Self-checking bench for cpm_top with the oscillator model.
// Assumes main clock steps equal aclk cycles and a shortened PLL lock.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdv;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        wait_exec = 1'h0, irq_pending = 1'h0, wake_event = 1'h0, link_sleep = 1'h0;
    logic        low_osc_tick, main_osc_stable, main_osc_enable, pll_enable, cpu_stall;
    logic [2:0]  pll_multiplier;
    logic        sys_clk_en, slow_clk_en, timer_clk_en, aux1_clk_en, aux2_clk_en;
    int          mismatches = 0, num_checks = 0;
    cpm_top #(.PLL_LOCK_CYC(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wait_exec(wait_exec), .irq_pending(irq_pending), .wake_event(wake_event), .link_sleep(link_sleep),
        .low_osc_tick(low_osc_tick), .main_osc_stable(main_osc_stable), .main_osc_enable(main_osc_enable),
        .pll_enable(pll_enable), .pll_multiplier(pll_multiplier), .sys_clk_en(sys_clk_en),
        .slow_clk_en(slow_clk_en), .timer_clk_en(timer_clk_en), .aux1_clk_en(aux1_clk_en),
        .aux2_clk_en(aux2_clk_en), .cpu_stall(cpu_stall));
    cpm_osc_model i_osc (.aclk(aclk), .aresetn(aresetn), .main_osc_enable(main_osc_enable),
        .main_osc_stable(main_osc_stable), .low_osc_tick(low_osc_tick));
    // ==========================================
    // Shared tasks
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo;
        chk(32'h0, 32'h1);
        wrap_up;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid && n < 50);
        bready <= 1'h0;
        if (n >= 50) tmo;
        chk(bresp, 2'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (!rvalid && n < 50);
        rready <= 1'h0;
        if (n >= 50) tmo;
        rdv = rdata;
        chk(rresp, er);
    endtask
    function automatic logic clks(input int s);
        logic [3:0] v;
        v = {aux2_clk_en, aux1_clk_en, slow_clk_en, sys_clk_en};
        return v[s];
    endfunction
    // Third interval is measured so a divisor change has settled
    task automatic period(input int sel, input int exp);
        int n, c;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            c = 0;
            do begin
                @(posedge aclk);
                n++;
                c++;
            end while (clks(sel) !== 1'h1 && n < 3000);
        end
        if (n >= 3000) tmo;
        chk(c, exp);
    endtask
    task automatic quiet(input int sel, input int cyc);
        int c;
        c = 0;
        repeat (cyc) begin
            @(posedge aclk);
            if (clks(sel) !== 1'h0) c++;
        end
        chk(c, 0);
    endtask
    task automatic kick(input bit wake);
        @(posedge aclk);
        if (wake) wake_event <= 1'h1;
        else wait_exec <= 1'h1;
        @(posedge aclk);
        wake_event <= 1'h0;
        wait_exec <= 1'h0;
        repeat (20) @(posedge aclk);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
        logic [7:0] e [6] = '{8'h4f, 8'hb6, 8'hff, 8'h06, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(a[i], (i == 5) ? 2'h2 : 2'h0);
            chk(rdv, {24'h0, e[i]});
        end
        chk(pll_multiplier, 3'h4);
        $display("test reset done");
    endtask
    task automatic t_mult;
        logic [2:0] m;
        m = 3'h4;
        wr(8'h0c, 32'h06);
        wr(8'h0c, 32'h04);
        rd(8'h0c, 2'h0);
        chk(rdv, 32'h06);
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, {25'h0, c[2:0], 4'hf});
            if (c >= 3 && c <= 5) m = c[2:0];
            chk(pll_multiplier, m);
        end
        wr(8'h00, 32'h4f);
        $display("test multiplier done");
    endtask
    task automatic t_div;
        wr(8'h0c, 32'h1e);
        for (int f = 0; f < 16; f += 5) begin
            wr(8'h00, {24'h0, 4'h4, f[3:0]});
            period(0, f + 1);
        end
        wr(8'h08, 32'hf3);
        period(2, 4);
        period(3, 16);
        wr(8'h08, 32'h0e);
        period(2, 15);
        period(3, 1);
        wr(8'h04, 32'h02);
        period(1, 6);
        wr(8'h04, 32'h00);
        period(1, 2);
        wr(8'h0c, 32'h06);
        quiet(2, 40);
        quiet(3, 40);
        $display("test dividers done");
    endtask
    task automatic t_stall;
        kick(1'b0);
        chk(cpu_stall, 1'h1);
        irq_pending <= 1'h1;
        repeat (4) @(posedge aclk);
        chk(cpu_stall, 1'h0);
        irq_pending <= 1'h0;
        $display("test wait done");
    endtask
    task automatic t_save;
        wr(8'h0c, 32'h1f);
        wr(8'h10, 32'h41);
        kick(1'b0);
        rd(8'h14, 2'h0);
        chk(rdv[1:0], 2'h1);
        link_sleep <= 1'h1;
        repeat (10) @(posedge aclk);
        chk(main_osc_enable, 1'h0);
        quiet(2, 30);
        link_sleep <= 1'h0;
        repeat (20) @(posedge aclk);
        chk(main_osc_enable, 1'h1);
        wr(8'h10, 32'h51);
        repeat (5) @(posedge aclk);
        chk(main_osc_enable, 1'h0);
        chk(pll_enable, 1'h0);
        kick(1'b1);
        chk(main_osc_enable, 1'h1);
        rd(8'h14, 2'h0);
        chk(rdv[1:0], 2'h0);
        $display("test save done");
    endtask
    task automatic t_halt;
        wr(8'h10, 32'h04);
        kick(1'b0);
        chk(main_osc_enable, 1'h0);
        chk(pll_enable, 1'h0);
        quiet(0, 40);
        quiet(1, 40);
        rd(8'h00, 2'h0);
        chk(rdv, 32'h4f);
        kick(1'b1);
        rd(8'h14, 2'h0);
        chk(rdv[1:0], 2'h0);
        chk(main_osc_enable, 1'h1);
        $display("test halt done");
    endtask
    initial begin
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_mult;
        t_div;
        t_stall;
        t_save;
        t_halt;
        wrap_up;
    end
endmodule
